//--- motor_ctrl_pkg.sv
// package: register offsets, encodings, defaults and timing counts
// assumes a 32-bit axi4-lite register bus and a 200 MHz clock
package motor_ctrl_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] MOTOR_OFF = 8'h04;
  localparam logic [7:0] SLIP_OFF = 8'h08;
  localparam logic [7:0] CURR_OFF = 8'h0c;
  localparam logic [7:0] MISC_OFF = 8'h10;
  localparam logic [7:0] GAIN_OFF = 8'h14;
  localparam logic [7:0] BOOST_OFF = 8'h18;
  localparam logic [7:0] TUNE_OFF = 8'h1c;
  localparam logic [7:0] REF_OFF = 8'h20;
  localparam logic [7:0] STAT_OFF = 8'h24;
  localparam logic [7:0] OUT_OFF = 8'h28;
  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] MODE_VF = 2'h0;
  localparam logic [1:0] MODE_SLIP = 2'h1;
  localparam logic [1:0] MODE_SENSORLESS = 2'h2;
  localparam logic [1:0] PATTERN_USER = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // defaults (frequency 0.01 Hz, current 0.1 A, time 0.1 s units)
  // ****************************************************************
  localparam logic [15:0] SLIP_DEF = 16'h00ea;
  localparam logic [15:0] RATED_CURR_DEF = 16'h00c5;
  localparam logic [15:0] NOLOAD_CURR_DEF = 16'h0042;
  localparam logic [7:0] EFF_DEF = 8'h56;
  localparam logic [7:0] INERTIA_DEF = 8'h00;
  localparam logic [9:0] PREEX_DEF = 10'h00a;
  localparam logic [9:0] PREEX_MAX = 10'h258;
  localparam logic [15:0] PGAIN_DEF = 16'h03e8;
  localparam logic [15:0] IGAIN_DEF = 16'h0064;
  localparam logic [3:0] BOOST_DEF = 4'h2;
  localparam logic [3:0] BOOST_MAX = 4'hf;
  localparam logic [15:0] RS_DEF = 16'h0100;
  localparam logic [15:0] RR_DEF = 16'h0100;
  localparam logic [15:0] LSIG_DEF = 16'h0100;
  // ****************************************************************
  // timing: pre-excitation tick is 0.1 s
  // ****************************************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int PREEX_TICK_MS = 100;
  localparam int PREEX_TICK_CYCLES = CLK_HZ / 1000 * PREEX_TICK_MS;
  localparam int TUNE_STEP_CYCLES = 4096;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREEX = 3'b001,
    ST_RUN = 3'b010,
    ST_TUNE = 3'b011
  } run_state_t;
  typedef struct packed {
    logic [15:0] slip;
    logic [15:0] rated_curr;
    logic [15:0] noload_curr;
    logic [7:0] efficiency;
    logic [7:0] inertia;
  } motor_set_t;
endpackage

//--- inverter_control_mode_core.sv
// motor control core: slip, tuning, pre-excitation, speed gains, torque boost
// assumes an axi4-lite master and inputs synchronous to aclk
// Summary of operation
// R01 - slip correction equals rated slip times load share above no-load current
// R02 - output frequency is reference plus slip correction
// R03 - slip correction clamped to plus or minus rated slip
// R04 - motor capacity change loads default slip, currents, efficiency, inertia
// R05 - control method 0 volts-per-hertz, 1 slip compensation, 2 sensorless
// R06 - auto tune request 1 starts tuning, 0 default leaves it off
// R07 - tuning measures resistances, leakage, no-load current and stores them
// R08 - operator enters nameplate data before tuning; keeps preset efficiency if unknown
// R09 - run command pre-excites motor for programmed time, default 1 s, 0-60 s
// R10 - normal output begins only after pre-excitation fully elapses
// R11 - sensorless proportional gain setting used, default 1000
// R12 - sensorless integral gain setting used, default 100
// R13 - manual boost uses forward level forward, reverse level reverse
// R14 - boost level is percent of rated voltage, default 2, range 0-15
// R15 - user volts-per-hertz pattern ignores boost method and levels
// R16 - automatic boost raises voltage by load to give starting torque
// R17 - no automatic boost under sensorless control
// R18 - automatic boost only for first motor set; second uses manual
// R19 - slip correction only in slip compensation mode, else reference frequency
`timescale 1ns/100ps
module inverter_control_mode_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic run_forward,
  input wire logic run_reverse,
  input wire logic [15:0] output_current,
  input wire logic [15:0] tune_measure,
  output logic [15:0] output_frequency,
  output logic [3:0] voltage_boost,
  output logic auto_boost_active,
  output logic pre_excite_active,
  output logic normal_run,
  output logic tune_busy,
  output logic [15:0] speed_kp,
  output logic [15:0] speed_ki
);
  // ****************************************************************
  // register state
  // ****************************************************************
  logic [1:0] ctl_method_reg, ctl_method_next;
  logic [1:0] vf_pattern_reg, vf_pattern_next;
  logic second_motor_reg, second_motor_next;
  logic [7:0] motor_capacity_select_reg, motor_capacity_select_next;
  motor_ctrl_pkg::motor_set_t motor_reg, motor_next;
  logic [9:0] preex_time_reg, preex_time_next;
  logic [15:0] kp_reg, kp_next, ki_reg, ki_next;
  logic boost_auto_reg, boost_auto_next;
  logic [3:0] fwd_boost_reg, fwd_boost_next, rev_boost_reg, rev_boost_next;
  logic [15:0] rs_reg, rs_next, rr_reg, rr_next, lsig_reg, lsig_next;
  logic [15:0] ref_freq_reg, ref_freq_next;
  logic tune_req;
  // bus handshake state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  always_comb begin
    logic have_aw;
    logic have_w;
    have_aw = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
    have_w = w_hold_reg || (s_axi_wvalid && s_axi_wready);
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wdata_next = w_hold_reg ? wdata_reg : s_axi_wdata;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    wr_fire = have_aw && have_w && !bvalid_reg;
    wr_addr = awaddr_next;
    wr_data = wdata_next;
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wr_addr[7:2] <= motor_ctrl_pkg::OUT_OFF[7:2]) ?
                   motor_ctrl_pkg::RESP_OKAY : motor_ctrl_pkg::RESP_SLVERR;
    end else begin
      aw_hold_next = have_aw;
      w_hold_next = have_w;
    end
  end
  // ****************************************************************
  // control state
  // ****************************************************************
  motor_ctrl_pkg::run_state_t state_reg, state_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [9:0] preex_cnt_reg, preex_cnt_next;
  logic [1:0] tune_step_reg, tune_step_next;
  logic run_cmd;
  assign run_cmd = run_forward || run_reverse;
  // ****************************************************************
  // register writes and tuning results
  // ****************************************************************
  always_comb begin
    ctl_method_next = ctl_method_reg;
    vf_pattern_next = vf_pattern_reg;
    second_motor_next = second_motor_reg;
    motor_capacity_select_next = motor_capacity_select_reg;
    motor_next = motor_reg;
    preex_time_next = preex_time_reg;
    kp_next = kp_reg;
    ki_next = ki_reg;
    boost_auto_next = boost_auto_reg;
    fwd_boost_next = fwd_boost_reg;
    rev_boost_next = rev_boost_reg;
    rs_next = rs_reg;
    rr_next = rr_reg;
    lsig_next = lsig_reg;
    ref_freq_next = ref_freq_reg;
    tune_req = 1'b0;
    if (wr_fire) begin
      case (wr_addr)
        motor_ctrl_pkg::CTRL_OFF: begin
          if (wr_data[1:0] <= motor_ctrl_pkg::MODE_SENSORLESS) begin
            ctl_method_next = wr_data[1:0]; // R05
          end
          vf_pattern_next = wr_data[5:4];
          second_motor_next = wr_data[8];
        end
        motor_ctrl_pkg::MOTOR_OFF: begin
          motor_capacity_select_next = wr_data[7:0];
          motor_next.efficiency = wr_data[15:8];
          motor_next.inertia = wr_data[23:16];
          if (wr_data[7:0] != motor_capacity_select_reg) begin
            motor_next.slip = motor_ctrl_pkg::SLIP_DEF; // R04
            motor_next.rated_curr = motor_ctrl_pkg::RATED_CURR_DEF; // R04
            motor_next.noload_curr = motor_ctrl_pkg::NOLOAD_CURR_DEF; // R04
            motor_next.efficiency = motor_ctrl_pkg::EFF_DEF; // R04
            motor_next.inertia = motor_ctrl_pkg::INERTIA_DEF; // R04
          end
        end
        motor_ctrl_pkg::SLIP_OFF: motor_next.slip = wr_data[15:0];
        motor_ctrl_pkg::CURR_OFF: begin
          motor_next.rated_curr = wr_data[15:0];
          motor_next.noload_curr = wr_data[31:16];
        end
        motor_ctrl_pkg::MISC_OFF: begin
          if (wr_data[9:0] <= motor_ctrl_pkg::PREEX_MAX) begin
            preex_time_next = wr_data[9:0]; // R09
          end
        end
        motor_ctrl_pkg::GAIN_OFF: begin
          kp_next = wr_data[15:0];
          ki_next = wr_data[31:16];
        end
        motor_ctrl_pkg::BOOST_OFF: begin
          boost_auto_next = wr_data[0];
          fwd_boost_next = wr_data[7:4]; // R14
          rev_boost_next = wr_data[11:8]; // R14
        end
        motor_ctrl_pkg::TUNE_OFF: tune_req = wr_data[0]; // R06
        motor_ctrl_pkg::REF_OFF: ref_freq_next = wr_data[15:0];
        default: ;
      endcase
    end
    // tuning stores one measurement per step
    if (state_reg == motor_ctrl_pkg::ST_TUNE &&
        tick_cnt_reg == 32'(motor_ctrl_pkg::TUNE_STEP_CYCLES - 1)) begin
      case (tune_step_reg)
        2'h0: rs_next = tune_measure; // R07
        2'h1: rr_next = tune_measure; // R07
        2'h2: lsig_next = tune_measure; // R07
        default: motor_next.noload_curr = tune_measure; // R07
      endcase
    end
  end
  // ****************************************************************
  // run sequencer: tuning, pre-excitation, normal run
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    tick_cnt_next = tick_cnt_reg;
    preex_cnt_next = preex_cnt_reg;
    tune_step_next = tune_step_reg;
    case (state_reg)
      motor_ctrl_pkg::ST_IDLE: begin
        tick_cnt_next = 32'h0;
        preex_cnt_next = 10'h0;
        tune_step_next = 2'h0;
        if (tune_req) begin
          state_next = motor_ctrl_pkg::ST_TUNE; // R06
        end else if (run_cmd) begin
          state_next = (preex_time_reg == 10'h0) ?
                       motor_ctrl_pkg::ST_RUN : motor_ctrl_pkg::ST_PREEX; // R09
        end
      end
      motor_ctrl_pkg::ST_PREEX: begin
        if (!run_cmd) begin
          state_next = motor_ctrl_pkg::ST_IDLE;
        end else if (tick_cnt_reg == 32'(motor_ctrl_pkg::PREEX_TICK_CYCLES - 1)) begin
          tick_cnt_next = 32'h0;
          preex_cnt_next = preex_cnt_reg + 10'h1;
          if (preex_cnt_reg + 10'h1 >= preex_time_reg) begin
            state_next = motor_ctrl_pkg::ST_RUN; // R10
          end
        end else begin
          tick_cnt_next = tick_cnt_reg + 32'h1;
        end
      end
      motor_ctrl_pkg::ST_RUN: begin
        if (!run_cmd) begin
          state_next = motor_ctrl_pkg::ST_IDLE;
        end
      end
      motor_ctrl_pkg::ST_TUNE: begin
        if (tick_cnt_reg == 32'(motor_ctrl_pkg::TUNE_STEP_CYCLES - 1)) begin
          tick_cnt_next = 32'h0;
          tune_step_next = tune_step_reg + 2'h1;
          if (tune_step_reg == 2'h3) begin
            state_next = motor_ctrl_pkg::ST_IDLE;
          end
        end else begin
          tick_cnt_next = tick_cnt_reg + 32'h1;
        end
      end
      default: state_next = motor_ctrl_pkg::ST_IDLE;
    endcase
  end
  // ****************************************************************
  // slip compensation and boost
  // ****************************************************************
  logic [15:0] freq_next;
  logic [3:0] boost_next;
  logic auto_next;
  always_comb begin
    logic signed [17:0] load_share;
    logic signed [17:0] span;
    logic signed [35:0] product;
    logic signed [35:0] delta;
    logic signed [17:0] slip_lim;
    logic signed [17:0] sum;
    load_share = 18'(signed'({2'b00, output_current})) -
                 18'(signed'({2'b00, motor_reg.noload_curr}));
    span = 18'(signed'({2'b00, motor_reg.rated_curr})) -
           18'(signed'({2'b00, motor_reg.noload_curr}));
    slip_lim = 18'(signed'({2'b00, motor_reg.slip}));
    product = 36'(slip_lim) * 36'(load_share); // R01
    // non-positive span: skip the divide, no correction
    delta = (span > 18'sh0) ? product / 36'(span) : 36'sh0; // R01
    if (delta > 36'(slip_lim)) begin
      delta = 36'(slip_lim); // R03
    end else if (delta < -36'(slip_lim)) begin
      delta = -36'(slip_lim); // R03
    end
    if (ctl_method_reg != motor_ctrl_pkg::MODE_SLIP) begin
      delta = 36'sh0; // R19
    end
    sum = 18'(signed'({2'b00, ref_freq_reg})) + 18'(delta); // R02
    freq_next = (sum < 18'sh0) ? 16'h0 : (sum > 18'sh0ffff) ? 16'hffff : sum[15:0];
    boost_next = 4'h0;
    auto_next = 1'b0;
    if (vf_pattern_reg != motor_ctrl_pkg::PATTERN_USER) begin // R15
      if (boost_auto_reg && !second_motor_reg) begin // R18
        auto_next = (ctl_method_reg != motor_ctrl_pkg::MODE_SENSORLESS); // R17
        if (auto_next && load_share > 18'sh0) begin
          boost_next = (load_share >= span) ? motor_ctrl_pkg::BOOST_MAX :
                       4'(22'(load_share) * 22'sd15 / 22'(span)); // R16
        end
      end else begin
        boost_next = run_reverse ? rev_boost_reg : fwd_boost_reg; // R13
      end
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= motor_ctrl_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= motor_ctrl_pkg::RESP_OKAY;
      rdata_reg <= 32'h0;
      ctl_method_reg <= motor_ctrl_pkg::MODE_VF;
      vf_pattern_reg <= 2'h0;
      second_motor_reg <= 1'b0;
      motor_capacity_select_reg <= 8'h0;
      motor_reg <= '{motor_ctrl_pkg::SLIP_DEF, motor_ctrl_pkg::RATED_CURR_DEF,
                     motor_ctrl_pkg::NOLOAD_CURR_DEF, motor_ctrl_pkg::EFF_DEF,
                     motor_ctrl_pkg::INERTIA_DEF};
      preex_time_reg <= motor_ctrl_pkg::PREEX_DEF;
      kp_reg <= motor_ctrl_pkg::PGAIN_DEF; // R11
      ki_reg <= motor_ctrl_pkg::IGAIN_DEF; // R12
      boost_auto_reg <= 1'b0;
      fwd_boost_reg <= motor_ctrl_pkg::BOOST_DEF;
      rev_boost_reg <= motor_ctrl_pkg::BOOST_DEF;
      rs_reg <= motor_ctrl_pkg::RS_DEF;
      rr_reg <= motor_ctrl_pkg::RR_DEF;
      lsig_reg <= motor_ctrl_pkg::LSIG_DEF;
      ref_freq_reg <= 16'h0;
      state_reg <= motor_ctrl_pkg::ST_IDLE;
      tick_cnt_reg <= 32'h0;
      preex_cnt_reg <= 10'h0;
      tune_step_reg <= 2'h0;
      output_frequency <= 16'h0;
      voltage_boost <= 4'h0;
      auto_boost_active <= 1'b0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctl_method_reg <= ctl_method_next;
      vf_pattern_reg <= vf_pattern_next;
      second_motor_reg <= second_motor_next;
      motor_capacity_select_reg <= motor_capacity_select_next;
      motor_reg <= motor_next;
      preex_time_reg <= preex_time_next;
      kp_reg <= kp_next;
      ki_reg <= ki_next;
      boost_auto_reg <= boost_auto_next;
      fwd_boost_reg <= fwd_boost_next;
      rev_boost_reg <= rev_boost_next;
      rs_reg <= rs_next;
      rr_reg <= rr_next;
      lsig_reg <= lsig_next;
      ref_freq_reg <= ref_freq_next;
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      preex_cnt_reg <= preex_cnt_next;
      tune_step_reg <= tune_step_next;
      output_frequency <= freq_next;
      voltage_boost <= boost_next;
      auto_boost_active <= auto_next;
    end
  end
  assign pre_excite_active = (state_reg == motor_ctrl_pkg::ST_PREEX); // R09
  assign normal_run = (state_reg == motor_ctrl_pkg::ST_RUN); // R10
  assign tune_busy = (state_reg == motor_ctrl_pkg::ST_TUNE);
  assign speed_kp = kp_reg; // R11
  assign speed_ki = ki_reg; // R12
  // ****************************************************************
  // read path
  // ****************************************************************
  always_comb begin
    rvalid_next = rvalid_reg && !s_axi_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = motor_ctrl_pkg::RESP_OKAY;
      case (s_axi_araddr)
        motor_ctrl_pkg::CTRL_OFF:
          rdata_next = {23'h0, second_motor_reg, 2'h0, vf_pattern_reg, 2'h0, ctl_method_reg};
        motor_ctrl_pkg::MOTOR_OFF: rdata_next = {8'h0, motor_reg.inertia,
                                                 motor_reg.efficiency, motor_capacity_select_reg};
        motor_ctrl_pkg::SLIP_OFF: rdata_next = {16'h0, motor_reg.slip};
        motor_ctrl_pkg::CURR_OFF: rdata_next = {motor_reg.noload_curr, motor_reg.rated_curr};
        motor_ctrl_pkg::MISC_OFF: rdata_next = {22'h0, preex_time_reg};
        motor_ctrl_pkg::GAIN_OFF: rdata_next = {ki_reg, kp_reg};
        motor_ctrl_pkg::BOOST_OFF:
          rdata_next = {20'h0, rev_boost_reg, fwd_boost_reg, 3'h0, boost_auto_reg};
        motor_ctrl_pkg::TUNE_OFF: rdata_next = {rr_reg, 15'h0, tune_busy};
        motor_ctrl_pkg::REF_OFF: rdata_next = {16'h0, ref_freq_reg};
        motor_ctrl_pkg::STAT_OFF: rdata_next = {lsig_reg, rs_reg};
        motor_ctrl_pkg::OUT_OFF: rdata_next = {7'h0, auto_boost_active, voltage_boost,
                                               2'h0, pre_excite_active, normal_run,
                                               output_frequency};
        default: begin
          rdata_next = 32'h0;
          rresp_next = motor_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
  end
endmodule // inverter_control_mode_core

//--- motor_ctrl_checker.sv
// checker: run sequencing, tuning and gain properties
// assumes a bind into the core, one clock domain
`timescale 1ns/100ps
module motor_ctrl_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic run_forward,
  input wire logic run_reverse,
  input wire logic pre_excite_active,
  input wire logic normal_run,
  input wire logic tune_busy,
  input wire logic [15:0] speed_kp,
  input wire logic [15:0] speed_ki
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_phase_excl: assert property (!(pre_excite_active && normal_run))
    else $error("preexcite and run together");
  a_preex_hold: assert property ($rose(pre_excite_active) |-> !normal_run[*8])
    else $error("run too early");
  a_preex_cause: assert property ($rose(pre_excite_active) |->
    $past(run_forward) || $past(run_reverse)) else $error("preexcite without run");
  a_run_stop: assert property (!run_forward && !run_reverse |->
    ##[1:2] !(pre_excite_active || normal_run)) else $error("output after stop");
  a_tune_hold: assert property ($rose(tune_busy) |-> tune_busy[*8])
    else $error("tuning ended early");
  a_tune_excl: assert property (tune_busy |-> !pre_excite_active && !normal_run)
    else $error("run during tuning");
  a_gain_reset: assert property ($rose(aresetn) |->
    speed_kp == motor_ctrl_pkg::PGAIN_DEF && speed_ki == motor_ctrl_pkg::IGAIN_DEF)
    else $error("gain defaults wrong");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule // motor_ctrl_checker
bind inverter_control_mode_core motor_ctrl_checker chk (.*);

//--- motor_model.sv
// motor model: load current and tuning readings
// assumes the bench sets the mechanical load; same clock as the core
`timescale 1ns/100ps
module motor_model #(parameter logic [15:0] MEAS = 16'h0123) (
  input wire logic aclk,
  input wire logic [15:0] load,
  input wire logic energised,
  input wire logic tune_busy,
  output logic [15:0] output_current = 16'h0000,
  output logic [15:0] tune_measure = 16'h0000
);
  always @(posedge aclk) begin
    // an unpowered motor draws no current
    output_current <= energised ? load : 16'h0000;
    // outside tuning the reading means nothing, so show its inverse
    tune_measure <= tune_busy ? MEAS : ~MEAS;
  end
endmodule // motor_model

//--- test_inverter_control_mode_core.sv
// testbench: directed scenarios for the motor control core
// assumes motor_model supplies load current and tuning readings
`timescale 1ns/100ps
module test_inverter_control_mode_core;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic run_forward = 1'h0, run_reverse = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic auto_boost_active, pre_excite_active, normal_run, tune_busy;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, voltage_boost;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] output_current, tune_measure, output_frequency, speed_kp, speed_ki;
  logic [15:0] load = 16'h0000;
  int bad_count = 0, n_compared = 0;
  inverter_control_mode_core dut (.*);
  motor_model motor (.aclk, .load, .energised(pre_excite_active | normal_run),
    .tune_busy, .output_current, .tune_measure);
  initial forever #2.5 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ****************************************************************
  // bus master: ready sampled at the falling edge
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ka, kw, kb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ka = s_axi_awready;
      kw = s_axi_wready;
      kb = s_axi_bvalid;
      if (kb) chk(s_axi_bresp, r);
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid & ~ka;
      s_axi_wvalid <= s_axi_wvalid & ~kw;
    end while (!kb);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic ka, kr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ka = s_axi_arready;
      kr = s_axi_rvalid;
      if (kr) begin
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
      end
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid & ~ka;
    end while (!kr);
    s_axi_rready <= 1'h0;
  endtask
  task automatic go(input logic f, input logic r, input logic [15:0] v);
    @(posedge aclk);
    run_forward <= f;
    run_reverse <= r;
    load <= v;
    repeat (4) @(negedge aclk);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_defaults;
    rc(motor_ctrl_pkg::MISC_OFF, motor_ctrl_pkg::PREEX_DEF);
    rc(motor_ctrl_pkg::BOOST_OFF, 32'h0000_0220);
    wr(motor_ctrl_pkg::GAIN_OFF, 32'h0055_0777);
    @(negedge aclk);
    chk({speed_ki, speed_kp}, 32'h0055_0777);
    wr(8'h30, 32'h0, motor_ctrl_pkg::RESP_SLVERR);
    rc(8'h2c, 32'h0, motor_ctrl_pkg::RESP_SLVERR);
    wr(motor_ctrl_pkg::SLIP_OFF, 32'h50);
    wr(motor_ctrl_pkg::MOTOR_OFF, 32'h0007_1101);
    rc(motor_ctrl_pkg::SLIP_OFF, motor_ctrl_pkg::SLIP_DEF);
    rc(motor_ctrl_pkg::MOTOR_OFF, {8'h00, motor_ctrl_pkg::INERTIA_DEF,
      motor_ctrl_pkg::EFF_DEF, 8'h01});
  endtask
  task automatic t_slip;
    logic [15:0] cur [3] = '{16'h00c5, 16'h0042, 16'h0148};
    logic [15:0] exp [3] = '{16'h10ea, 16'h1000, 16'h10ea};
    wr(motor_ctrl_pkg::MISC_OFF, 32'h0);
    wr(motor_ctrl_pkg::REF_OFF, 32'h1000);
    for (int m = 0; m < 3; m++) begin
      wr(motor_ctrl_pkg::CTRL_OFF, m);
      for (int i = 0; i < 3; i++) begin
        go(1'h1, 1'h0, cur[i]);
        chk(output_frequency, m == 1 ? exp[i] : 16'h1000);
      end
    end
    chk(normal_run, 1'h1);
  endtask
  task automatic t_boost;
    logic [31:0] cv [4] = '{32'h0, 32'h2, 32'h100, 32'h30};
    logic [4:0] bv [4] = '{5'h1f, 5'h00, 5'h05, 5'h00};
    wr(motor_ctrl_pkg::CTRL_OFF, 32'h0);
    wr(motor_ctrl_pkg::BOOST_OFF, 32'h0000_0590);
    go(1'h1, 1'h0, 16'h00c5);
    chk(voltage_boost, 4'h9);
    go(1'h0, 1'h0, 16'h00c5);
    go(1'h0, 1'h1, 16'h00c5);
    chk(voltage_boost, 4'h5);
    wr(motor_ctrl_pkg::BOOST_OFF, 32'h0000_0591);
    for (int i = 0; i < 4; i++) begin
      wr(motor_ctrl_pkg::CTRL_OFF, cv[i]);
      go(1'h0, 1'h1, 16'h00c5);
      chk({auto_boost_active, voltage_boost}, bv[i]);
    end
    go(1'h0, 1'h0, 16'h0000);
  endtask
  task automatic t_preex;
    wr(motor_ctrl_pkg::MISC_OFF, 32'h259);
    rc(motor_ctrl_pkg::MISC_OFF, 32'h0);
    wr(motor_ctrl_pkg::MISC_OFF, 32'h258);
    rc(motor_ctrl_pkg::MISC_OFF, 32'h258);
    wr(motor_ctrl_pkg::MISC_OFF, 32'h1);
    go(1'h1, 1'h0, 16'h00c5);
    chk({pre_excite_active, normal_run}, 2'h2);
    repeat (20) @(negedge aclk);
    chk({pre_excite_active, normal_run}, 2'h2);
    go(1'h0, 1'h0, 16'h0000);
    chk({pre_excite_active, normal_run}, 2'h0);
  endtask
  task automatic t_tune;
    wr(motor_ctrl_pkg::TUNE_OFF, 32'h0);
    go(1'h0, 1'h0, 16'h0000);
    chk(tune_busy, 1'h0);
    // nameplate data stays at the loaded defaults
    wr(motor_ctrl_pkg::TUNE_OFF, 32'h1);
    @(negedge aclk);
    chk(tune_busy, 1'h1);
    for (int i = 0; i < 20000 && tune_busy; i++) @(negedge aclk);
    chk(tune_busy, 1'h0);
    rc(motor_ctrl_pkg::STAT_OFF, 32'h0123_0123);
    rc(motor_ctrl_pkg::TUNE_OFF, 32'h0123_0000);
    rc(motor_ctrl_pkg::CURR_OFF, {16'h0123, motor_ctrl_pkg::RATED_CURR_DEF});
  endtask
  task automatic final_report;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_defaults();
    t_slip();
    t_boost();
    t_preex();
    t_tune();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    final_report();
  end
endmodule // test_inverter_control_mode_core
